// file: common/ook_rx_regs.vh
// Register offsets, field positions, reset values and timing counts of the OOK/bit-sync receiver
`ifndef OOK_RX_REGS_VH
`define OOK_RX_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL      4'h0
`define OFS_FLOOR     4'h4
`define OFS_RATE      4'h8
`define OFS_STATUS    4'hC

// ****************************************
// Control register fields (low bit of each)
// ****************************************
`define F_MODE        0
`define F_OOK_SEL     2
`define F_SYNC_OFF    3
`define F_THR_TYPE    4
`define F_DECAY_STEP  6
`define F_DECAY_PER   9
`define F_CUTOFF      12
`define CTRL_WIDTH    14

// ****************************************
// Reset values
// ****************************************
`define CTRL_RST      14'h0010
`define FLOOR_RST     8'h0C
`define RATE_RST      8'h07

// ****************************************
// Encodings
// ****************************************
`define MODE_CONT     2'h0
`define THR_FIXED     2'h0
`define THR_PEAK      2'h1
`define THR_AVERAGE   2'h2

// ****************************************
// Slicer and timing constants
// ****************************************
// Signal strength is in 0.5 dB units, so 6 dB is twelve counts
`define PEAK_DROP     9'h00C
`define OS_CENTRE     4'h8
`define OS_LAST       4'hF

`endif

// file: hdl/bit_rate_timer.v
// Bit-rate divider giving oversample, chip and threshold-decay enable pulses
`timescale 1ns/1ps
module bit_rate_timer (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire [7:0] bit_rate_divider_in,
	input  wire [2:0] decay_period_in,
	output reg        os_tick_out,
	output reg        chip_tick_out,
	output reg        decay_tick_out
);
`include "ook_rx_regs.vh"

	reg  [9:0] cnt;
	reg  [3:0] os_phase;
	reg  [2:0] chip_div;
	wire [9:0] limit;
	reg  [2:0] mask;
	reg        decay_hit;

	// Sixteen ticks of (1+divider)*4 clocks make one bit of 64*(1+divider) clocks
	assign limit = {bit_rate_divider_in, 2'b11};

	always @* begin
		mask = 3'h0;
		case (decay_period_in[1:0])
			2'h0: mask = decay_period_in[2] ? 3'h7 : 3'h0;
			2'h1: mask = decay_period_in[2] ? 3'h3 : 3'h1;
			2'h2: mask = decay_period_in[2] ? 3'h1 : 3'h3;
			default: mask = decay_period_in[2] ? 3'h0 : 3'h7;
		endcase
		if (decay_period_in[2]) begin
			decay_hit = (os_phase[2:0] & mask) == mask;
		end else begin
			decay_hit = (os_phase == `OS_LAST) && ((chip_div & mask) == mask);
		end
	end

	// ****************************************
	// Divider chain
	// ****************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			cnt            <= 10'h000;
			os_phase       <= 4'h0;
			chip_div       <= 3'h0;
			os_tick_out    <= 1'b0;
			chip_tick_out  <= 1'b0;
			decay_tick_out <= 1'b0;
		end else begin
			os_tick_out    <= 1'b0;
			chip_tick_out  <= 1'b0;
			decay_tick_out <= 1'b0;
			if (cnt >= limit) begin
				cnt            <= 10'h000;
				os_tick_out    <= 1'b1;
				os_phase       <= os_phase + 4'h1;
				decay_tick_out <= decay_hit;
				if (os_phase == `OS_LAST) begin
					// One chip is one bit period of the same divider
					chip_tick_out <= 1'b1;
					chip_div      <= chip_div + 3'h1;
				end
			end else begin
				cnt <= cnt + 10'h001;
			end
		end
	end
endmodule // bit_rate_timer

// file: hdl/bit_sync_loop.v
// Bit synchroniser: sixteen-phase loop recovering a data clock centred on each bit
`timescale 1ns/1ps
module bit_sync_loop (
	input  wire clk_in,
	input  wire rst_in,
	input  wire os_tick_in,
	input  wire data_in,
	output reg  data_out,
	output reg  clock_out,
	output reg  strobe_out
);
`include "ook_rx_regs.vh"

	reg [3:0] phase;
	reg       prev;
	reg [3:0] next_phase;

	// An edge should land where the phase wraps; late edges hold, early ones skip.
	// One step per edge keeps noise from jerking the clock, at the cost of a
	// preamble several edges long to pull in from a half-bit error.
	always @* begin
		next_phase = phase + 4'h1;
		if (data_in != prev) begin
			if (phase == 4'h0) begin
				next_phase = 4'h1;
			end else if (phase < `OS_CENTRE) begin
				next_phase = phase;
			end else begin
				next_phase = phase + 4'h2;
			end
		end
	end

	// ****************************************
	// Phase loop and centre sampling
	// ****************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			phase      <= 4'h0;
			prev       <= 1'b0;
			data_out   <= 1'b0;
			clock_out  <= 1'b0;
			strobe_out <= 1'b0;
		end else begin
			strobe_out <= 1'b0;
			if (os_tick_in) begin
				prev <= data_in;
				// Without edges the loop free-runs at the programmed rate
				phase <= next_phase;
				clock_out <= next_phase[3];
				if (next_phase[3] && !phase[3]) begin
					data_out   <= data_in;
					strobe_out <= 1'b1;
				end
			end
		end
	end
endmodule // bit_sync_loop

// file: hdl/ook_rx_backend.v
// Receive back end: FSK polarity, OOK slicer, bit synchroniser and data routing
// Functional notes
// - FSK bit comes from I/Q phase order; raw or synchronised in continuous mode.
// - OOK bit compares signal strength with a peak, fixed or average threshold.
// - Peak threshold is tracked peak less 6 dB.
// - Peak decays one step per period on zero or no signal; 0.5 to 6 dB.
// - Peak threshold stops falling at the floor level.
// - Decay period code: once per 1/2/4/8 chips or 2/4/8/16 per chip.
// - Fixed mode slices against floor level only.
// - Average mode low-passes strength; cutoff bit rate over 8 pi to 32 pi.
// - Sync bypassed when disable bit set and partner holds second line low.
// - Continuous mode with sync drives recovered clock on second line.
// - Buffered or packet mode forces the synchroniser on.
// - Bit rate is reference over 64 times one plus divider.
// - Recovered clock rises mid-bit and tracks later data transitions.
// - Matched rates keep lock through any run of equal bits.
// - Mismatch tolerates runs of about half rate over rate error.
// - Continuous mode drives data pin; other modes feed the FIFO.
// - Mode 00 continuous, 01 buffered, 1x packet.
`timescale 1ns/1ps
module ook_rx_backend (
	input  wire        CLK_IN,
	input  wire        RST_IN,
	input  wire [3:0]  AVS_ADDRESS_IN,
	input  wire        AVS_READ_IN,
	input  wire        AVS_WRITE_IN,
	input  wire [31:0] AVS_WRITEDATA_IN,
	input  wire [3:0]  AVS_BYTEENABLE_IN,
	output reg  [31:0] AVS_READDATA_OUT,
	output reg         AVS_WAITREQUEST_OUT,
	input  wire        I_SIGN_IN,
	input  wire        Q_SIGN_IN,
	input  wire [7:0]  RSSI_IN,
	input  wire        SECOND_IRQ_LINE_IN,
	output reg         SECOND_IRQ_LINE_OUT,
	output reg         SECOND_IRQ_LINE_OE_OUT,
	output reg         DATA_OUT,
	output reg         DATA_OE_OUT,
	output reg  [7:0]  FIFO_DATA_OUT,
	output reg         FIFO_WRITE_OUT
);
`include "ook_rx_regs.vh"

	// ****************************************
	// Registers and decoded fields
	// ****************************************
	reg  [`CTRL_WIDTH-1:0] ctrl;
	reg  [7:0]             ook_floor_level;
	reg  [7:0]             bit_rate_divider;
	wire [1:0]             data_path_mode_sel;
	wire                   ook_mode_sel;
	wire                   bit_sync_disable;
	wire [1:0]             ook_threshold_type_sel;
	wire [2:0]             ook_peak_decay_step;
	wire [2:0]             ook_peak_decay_period;
	wire [1:0]             ook_average_cutoff_sel;

	assign data_path_mode_sel     = ctrl[`F_MODE +: 2];
	assign ook_mode_sel           = ctrl[`F_OOK_SEL];
	assign bit_sync_disable       = ctrl[`F_SYNC_OFF];
	assign ook_threshold_type_sel = ctrl[`F_THR_TYPE +: 2];
	assign ook_peak_decay_step    = ctrl[`F_DECAY_STEP +: 3];
	assign ook_peak_decay_period  = ctrl[`F_DECAY_PER +: 3];
	assign ook_average_cutoff_sel = ctrl[`F_CUTOFF +: 2];

	// ****************************************
	// Input synchronisers
	// ****************************************
	reg  [7:0] rssi_meta;
	reg  [7:0] rssi_s;
	reg  [1:0] i_meta;
	reg  [1:0] q_meta;
	reg        i_s;
	reg        q_s;
	reg        pin_meta;
	reg        pin_s;

	// Strength words change slowly against this clock; a torn word lasts one cycle
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			rssi_meta <= 8'h00;
			rssi_s    <= 8'h00;
			i_meta    <= 2'h0;
			q_meta    <= 2'h0;
			i_s       <= 1'b0;
			q_s       <= 1'b0;
			pin_meta  <= 1'b1;
			pin_s     <= 1'b1;
		end else begin
			rssi_meta <= RSSI_IN;
			rssi_s    <= rssi_meta;
			i_meta    <= {i_meta[0], I_SIGN_IN};
			q_meta    <= {q_meta[0], Q_SIGN_IN};
			i_s       <= i_meta[1];
			q_s       <= q_meta[1];
			pin_meta  <= SECOND_IRQ_LINE_IN;
			pin_s     <= pin_meta;
		end
	end

	// ****************************************
	// Timing and FSK polarity
	// ****************************************
	wire os_tick;
	wire chip_tick;
	wire decay_tick;
	reg  i_prev;
	reg  fsk_bit;

	bit_rate_timer timer (
		.clk_in              (CLK_IN),
		.rst_in              (RST_IN),
		.bit_rate_divider_in (bit_rate_divider),
		.decay_period_in     (ook_peak_decay_period),
		.os_tick_out         (os_tick),
		.chip_tick_out       (chip_tick),
		.decay_tick_out      (decay_tick)
	);

	// At a rising I edge, Q low means I leads Q: a one
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			i_prev  <= 1'b0;
			fsk_bit <= 1'b0;
		end else begin
			i_prev <= i_s;
			if (i_s && !i_prev) begin
				fsk_bit <= ~q_s;
			end
		end
	end

	// ****************************************
	// OOK slicer
	// ****************************************
	reg  [8:0]  peak;
	reg  [15:0] avg_acc;
	reg  [8:0]  step;
	reg  [3:0]  avg_shift;
	reg  [7:0]  threshold;
	reg         ook_bit;
	wire [8:0]  peak_min;
	wire [8:0]  peak_dec;
	wire [8:0]  peak_thr;
	wire signed [16:0] avg_diff;
	wire signed [16:0] avg_delta;

	assign peak_min  = {1'b0, ook_floor_level} + `PEAK_DROP;
	assign peak_dec  = (peak > peak_min + step) ? peak - step : peak_min;
	assign peak_thr  = (peak > peak_min) ? peak - `PEAK_DROP : {1'b0, ook_floor_level};
	assign avg_diff  = $signed({1'b0, rssi_s, 8'h00}) - $signed({1'b0, avg_acc});
	assign avg_delta = avg_diff >>> avg_shift;

	always @* begin
		case (ook_peak_decay_step)
			3'h0: step = 9'h001;
			3'h1: step = 9'h002;
			3'h2: step = 9'h003;
			3'h3: step = 9'h004;
			3'h4: step = 9'h006;
			3'h5: step = 9'h008;
			3'h6: step = 9'h00A;
			default: step = 9'h00C;
		endcase
		// Updated sixteen times a bit: shift 6 gives about BR/(8 pi), 8 about BR/(32 pi)
		case (ook_average_cutoff_sel)
			2'h0: avg_shift = 4'h6;
			2'h1: avg_shift = 4'h7;
			2'h2: avg_shift = 4'h7;
			default: avg_shift = 4'h8;
		endcase
		case (ook_threshold_type_sel)
			`THR_FIXED: threshold = ook_floor_level;
			`THR_AVERAGE: threshold = avg_acc[15:8];
			default: threshold = peak_thr[7:0];
		endcase
	end

	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			peak    <= 9'h000;
			avg_acc <= 16'h0000;
			ook_bit <= 1'b0;
		end else begin
			ook_bit <= rssi_s > threshold;
			if ({1'b0, rssi_s} > peak) begin
				peak <= {1'b0, rssi_s};
			end else if (decay_tick && !ook_bit) begin
				peak <= peak_dec;
			end
			if (os_tick) begin
				avg_acc <= avg_acc + avg_delta[15:0];
			end
		end
	end

	// ****************************************
	// Bit synchroniser and path selection
	// ****************************************
	wire demod_bit;
	wire sync_data;
	wire sync_clock;
	wire sync_strobe;
	wire continuous;
	wire bypass;

	assign demod_bit  = ook_mode_sel ? ook_bit : fsk_bit;
	assign continuous = data_path_mode_sel == `MODE_CONT;
	// Only continuous mode may bypass; buffered and packet always synchronise
	assign bypass     = continuous && bit_sync_disable && !pin_s;

	// Relies on a preamble of alternating bits to pull the phase in
	bit_sync_loop sync (
		.clk_in     (CLK_IN),
		.rst_in     (RST_IN),
		.os_tick_in (os_tick),
		.data_in    (demod_bit),
		.data_out   (sync_data),
		.clock_out  (sync_clock),
		.strobe_out (sync_strobe)
	);

	reg [2:0] bit_cnt;
	reg [7:0] shift;

	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			DATA_OUT               <= 1'b0;
			DATA_OE_OUT            <= 1'b0;
			SECOND_IRQ_LINE_OUT    <= 1'b0;
			SECOND_IRQ_LINE_OE_OUT <= 1'b0;
			FIFO_DATA_OUT          <= 8'h00;
			FIFO_WRITE_OUT         <= 1'b0;
			bit_cnt                <= 3'h0;
			shift                  <= 8'h00;
		end else begin
			FIFO_WRITE_OUT <= 1'b0;
			DATA_OE_OUT    <= continuous;
			DATA_OUT       <= continuous & (bypass ? demod_bit : sync_data);
			// The line is released while disabled so the partner's level can be read
			SECOND_IRQ_LINE_OE_OUT <= continuous && !bit_sync_disable;
			SECOND_IRQ_LINE_OUT    <= sync_clock;
			if (continuous) begin
				bit_cnt <= 3'h0;
			end else if (sync_strobe) begin
				shift   <= {shift[6:0], sync_data};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					FIFO_DATA_OUT  <= {shift[6:0], sync_data};
					FIFO_WRITE_OUT <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	reg  [31:0] cur_word;
	wire [31:0] merged;
	wire        wr_take;

	always @* begin
		if (AVS_ADDRESS_IN == `OFS_CTRL) begin
			cur_word = {18'h0_0000, ctrl};
		end else if (AVS_ADDRESS_IN == `OFS_FLOOR) begin
			cur_word = {24'h00_0000, ook_floor_level};
		end else if (AVS_ADDRESS_IN == `OFS_RATE) begin
			cur_word = {24'h00_0000, bit_rate_divider};
		end else if (AVS_ADDRESS_IN == `OFS_STATUS) begin
			cur_word = {13'h0000, bypass, demod_bit, ook_bit, peak[7:0], threshold};
		end else begin
			cur_word = 32'h0000_0000;
		end
	end

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign merged[lane*8 +: 8] = AVS_BYTEENABLE_IN[lane] ?
				AVS_WRITEDATA_IN[lane*8 +: 8] : cur_word[lane*8 +: 8];
		end
	endgenerate

	// Every access is answered after exactly one wait cycle
	assign wr_take = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;

	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			AVS_WAITREQUEST_OUT <= 1'b1;
			AVS_READDATA_OUT    <= 32'h0000_0000;
			ctrl                <= `CTRL_RST;
			ook_floor_level     <= `FLOOR_RST;
			bit_rate_divider    <= `RATE_RST;
		end else begin
			if (!AVS_WAITREQUEST_OUT) begin
				AVS_WAITREQUEST_OUT <= 1'b1;
			end else if (AVS_READ_IN || AVS_WRITE_IN) begin
				AVS_WAITREQUEST_OUT <= 1'b0;
				AVS_READDATA_OUT    <= AVS_READ_IN ? cur_word : 32'h0000_0000;
			end
			if (wr_take) begin
				if (AVS_ADDRESS_IN == `OFS_CTRL) begin
					ctrl <= merged[`CTRL_WIDTH-1:0];
				end else if (AVS_ADDRESS_IN == `OFS_FLOOR) begin
					ook_floor_level <= merged[7:0];
				end else if (AVS_ADDRESS_IN == `OFS_RATE) begin
					bit_rate_divider <= merged[7:0];
				end
			end
		end
	end
endmodule // ook_rx_backend

// file: tb/ook_host_mcu.sv
// Host controller model on the data and second interrupt pins
`timescale 1ns/1ps
module ook_host_mcu (
	input  wire        clk_in,
	input  wire        hold_low_in,
	input  wire        line_in,
	input  wire        data_in,
	output reg         line_oe_out,
	output reg  [31:0] bits_out
);
	initial line_oe_out = 1'b0;
	initial bits_out = 32'h0000_0000;
	// Pulling the line low asks for the synchroniser bypass
	always @(posedge clk_in)
		line_oe_out <= hold_low_in;
	// Sample mid-bit on the falling clock, clear of the data update
	always @(negedge line_in)
		bits_out <= {bits_out[30:0], data_in};
endmodule // ook_host_mcu

// file: tb/ook_rx_assertions.sv
// Port-level checker for the receive back end
`timescale 1ns/1ps
module ook_rx_checker (
	input wire        CLK_IN,
	input wire        RST_IN,
	input wire [3:0]  AVS_ADDRESS_IN,
	input wire        AVS_READ_IN,
	input wire        AVS_WRITE_IN,
	input wire [31:0] AVS_WRITEDATA_IN,
	input wire [3:0]  AVS_BYTEENABLE_IN,
	input wire [31:0] AVS_READDATA_OUT,
	input wire        AVS_WAITREQUEST_OUT,
	input wire        SECOND_IRQ_LINE_OUT,
	input wire        SECOND_IRQ_LINE_OE_OUT,
	input wire        DATA_OUT,
	input wire        DATA_OE_OUT,
	input wire        FIFO_WRITE_OUT
);
	// ****************************************
	// Control shadow
	// ****************************************
	// Age guard lets the registered outputs follow a mode write
	reg [3:0] ctrl;
	reg [3:0] age;
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			ctrl <= 4'h0;
			age <= 4'h0;
		end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0
			&& AVS_BYTEENABLE_IN[0]) begin
			ctrl <= AVS_WRITEDATA_IN[3:0];
			age <= 4'h0;
		end else if (age != 4'hf)
			age <= age + 4'h1;
	end
	wire settled = age == 4'hf;
	wire cont = ctrl[1:0] == 2'h0;
	wire sync = cont && !ctrl[3];
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_ask;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
	endsequence
	sequence s_answer;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence
	a_bus_one_wait: assert property (s_ask |=> s_answer)
		else $error("bus answer late");
	a_unmapped_zero: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
		&& AVS_ADDRESS_IN[1:0] != 2'h0 |-> AVS_READDATA_OUT == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_fifo_cont_off: assert property (settled && cont |-> !FIFO_WRITE_OUT)
		else $error("fifo write in continuous mode");
	a_fifo_byte_gap: assert property (FIFO_WRITE_OUT |=> !FIFO_WRITE_OUT [*8])
		else $error("fifo writes too close");
	a_data_oe_mode: assert property (settled |-> DATA_OE_OUT == cont)
		else $error("data pin enable wrong");
	a_data_quiet_buf: assert property (settled && !cont |-> !DATA_OUT)
		else $error("data pin active outside continuous");
	a_clock_oe_mode: assert property (settled |-> SECOND_IRQ_LINE_OE_OUT == sync)
		else $error("recovered clock enable wrong");
	a_clock_high_run: assert property ($rose(SECOND_IRQ_LINE_OUT) |-> SECOND_IRQ_LINE_OUT [*8])
		else $error("recovered clock high too short");
	a_data_at_clock: assert property (settled && sync && $changed(DATA_OUT)
		|-> SECOND_IRQ_LINE_OUT)
		else $error("data moved while clock low");
endmodule // ook_rx_checker

bind ook_rx_backend ook_rx_checker chk_u (.*);

// file: tb/testbench.sv
// Self-checking bench for the receive back end
`timescale 1ns/1ps
module testbench;
	reg clk = 0, rst = 1, rd = 0, wr = 0, i_s = 0, q_s = 0, txb = 0, hold = 0;
	reg [3:0] adr = 4'h0, be = 4'hf;
	reg [31:0] wdat = 32'h0000_0000, v, w;
	reg [7:0] rssi = 8'h00, f, fbyte = 8'h00;
	reg [4:0] ph = 5'h00;
	wire [31:0] rdat, hist;
	wire [7:0] fdat;
	wire wreq, irq_o, irq_oe, dout, doe, fwr, moe;
	// Second line is pulled up when nobody drives it
	wire line = irq_oe ? irq_o : !moe;
	integer errors = 0, cmp_count = 0, cyc = 0, fcnt = 0, rd_len, i, n;
	ook_rx_backend dut_u (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .I_SIGN_IN(i_s), .Q_SIGN_IN(q_s),
		.RSSI_IN(rssi), .SECOND_IRQ_LINE_IN(line), .SECOND_IRQ_LINE_OUT(irq_o),
		.SECOND_IRQ_LINE_OE_OUT(irq_oe), .DATA_OUT(dout), .DATA_OE_OUT(doe),
		.FIFO_DATA_OUT(fdat), .FIFO_WRITE_OUT(fwr));
	ook_host_mcu mcu_u (.clk_in(clk), .hold_low_in(hold), .line_in(line), .data_in(dout),
		.line_oe_out(moe), .bits_out(hist));
	// ****************************************
	// Clock, sources and helpers
	// ****************************************
	always #4 clk = !clk;
	// 160 ns quadrature pair; I leading Q carries a one
	always @(posedge clk) begin
		ph <= (ph == 5'd19) ? 5'd0 : ph + 5'd1;
		i_s <= ph < 5'd10;
		q_s <= txb ? (ph >= 5'd5 && ph < 5'd15) : (ph >= 5'd15 || ph < 5'd5);
	end
	always @(posedge clk) if (fwr === 1'b1) begin
		fcnt <= fcnt + 1;
		fbyte <= fdat;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			errors = errors + 1;
			results;
		end
	end
	function [7:0] stp(input [2:0] s);
		stp = (s < 3'd4) ? s + 8'd1 : 2 * s - 8'd2;
	endfunction
	function integer nd(input [2:0] p);
		nd = (p < 3'd4) ? 8 >> p : 1 << (p - 3);
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task bus(input [3:0] a, input wt, input [31:0] d);
		begin
			adr <= a;
			wdat <= d;
			rd <= !wt;
			wr <= wt;
			rd_len = 0;
			@(posedge clk);
			while (wreq !== 1'b0) begin
				rd_len = rd_len + 1;
				@(posedge clk);
			end
			v = rdat;
			rd <= 1'b0;
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	// One bit is sixteen quadrature periods at divider 4
	task send(input b, input mid);
		begin
			txb <= b;
			repeat (160) @(posedge clk);
			if (mid) begin
				check(dout, b);
				check(irq_oe, 0);
			end
			repeat (160) @(posedge clk);
		end
	endtask
	task results;
		begin
			if (errors == 0 && cmp_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		v = $urandom(32'h43f1_befd);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(4'h0, 0, 0); check(v, 32'h0000_0010);
		bus(4'h4, 0, 0); check(v, 32'h0000_000c);
		bus(4'h8, 0, 0); check(v, 32'h0000_0007);
		bus(4'h2, 1, 32'hffff_ffff);
		bus(4'h2, 0, 0); check(v, 0);
		be <= 4'h0;
		bus(4'h8, 1, 32'h0000_0055);
		be <= 4'hf;
		bus(4'h8, 0, 0); check(v, 32'h0000_0007);
		bus(4'h8, 1, 0);
		bus(4'h0, 1, 32'h0000_0014);
		rssi <= 8'h80;
		repeat (16) @(posedge clk);
		bus(4'hc, 0, 0); check(v[16:0], 17'h1_8074);
		for (i = 0; i < 8; i = i + 1) begin
			bus(4'h0, 1, 32'h14 | i << 6 | i << 9);
			rssi <= 8'hf0;
			repeat (8) @(posedge clk);
			rssi <= 8'h00;
			repeat (8) @(posedge clk);
			bus(4'hc, 0, 0);
			w = v;
			repeat ((i < 4 ? 512 : 64) - rd_len - 2) @(posedge clk);
			bus(4'hc, 0, 0);
			check(v[15:8], w[15:8] - stp(i[2:0]) * nd(i[2:0]));
		end
		f = 8'h10 + $urandom % 64;
		bus(4'h4, 1, f);
		rssi <= 8'hf0;
		repeat (8) @(posedge clk);
		rssi <= 8'h00;
		repeat (300) @(posedge clk);
		bus(4'hc, 0, 0); check(v[15:0], {f + 8'h0c, f});
		bus(4'h0, 1, 32'h0000_0004);
		rssi <= f;
		repeat (8) @(posedge clk);
		bus(4'hc, 0, 0); check(v[16:0], {1'b0, f + 8'h0c, f});
		rssi <= f + 8'h01;
		repeat (8) @(posedge clk);
		bus(4'hc, 0, 0); check(v[16], 1);
		for (i = 0; i < 2; i = i + 1) begin
			bus(4'h0, 1, 32'h24 | (i * 3) << 12);
			f = 8'h20 + $urandom % 192;
			rssi <= f;
			repeat (2500 + i * 7500) @(posedge clk);
			bus(4'hc, 0, 0); check(v[7:0] === f || v[7:0] === f - 8'h01, 1);
		end
		bus(4'h8, 1, 4);
		bus(4'h0, 1, 32'h0000_0010);
		for (n = 0; n < 24; n = n + 1)
			send(n[0], 0);
		for (n = 0; n < 3; n = n + 1) begin
			w = n == 0 ? 16'hff00 : n == 1 ? 16'h00ff : $urandom;
			for (i = 15; i >= 0; i = i - 1)
				send(w[i], 0);
			repeat (4) send(!w[0], 0);
			v = 0;
			for (i = 0; i < 13; i = i + 1)
				if (hist[i +: 16] === w[15:0])
					v = 1;
			check(v, 1);
		end
		hold <= 1'b1;
		for (n = 1; n < 4; n = n + 1) begin
			bus(4'h0, 1, n | 32'h18);
			repeat (8) send(1, 0);
			i = fcnt;
			repeat (16) send(1, 0);
			check(fcnt - i, 2);
			check({fbyte, doe, dout}, 10'h3fc);
		end
		bus(4'h0, 1, 32'h0000_0018);
		repeat (8) send($urandom, 1);
		hold <= 1'b0;
		repeat (2) send(1, 0);
		results;
	end
endmodule // testbench
